// [include/pcr_pkg.sv]
// Purpose: constants and types for the parallel config port readback block
// Assumes: 40 MHz system clock, link logic on the configuration clock
// Notes:   header fields follow the type-1 / type-2 packet layout
package pcr_pkg;
   localparam int unsigned CLK_MHZ       = 40;
   localparam int unsigned SHUT_TIME_NS  = 1000;
   localparam int unsigned SHUT_CYCLES   = (SHUT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned START_TIME_NS = 1000;
   localparam int unsigned START_CYCLES  = (START_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  SHUT_LOAD     = 8'(SHUT_CYCLES - 1);
   localparam logic [7:0]  START_LOAD    = 8'(START_CYCLES - 1);

   localparam logic [31:0] SYNC_WORD     = 32'haa995566;
   localparam int unsigned TYPE_LSB      = 29;
   localparam int unsigned OP_LSB        = 27;
   localparam int unsigned REG_LSB       = 13;
   localparam int unsigned WC1_BITS      = 11;
   localparam int unsigned WC2_BITS      = 27;
   localparam logic [2:0]  HDR_TYPE1     = 3'h1;
   localparam logic [2:0]  HDR_TYPE2     = 3'h2;
   localparam logic [1:0]  OP_READ       = 2'h1;
   localparam logic [1:0]  OP_WRITE      = 2'h2;

   localparam logic [4:0]  REG_FAR       = 5'h01;
   localparam logic [4:0]  REG_FRAME_READOUT_REGISTER      = 5'h03;
   localparam logic [4:0]  REG_CMD       = 5'h04;
   localparam logic [4:0]  REG_STAT      = 5'h07;

   localparam logic [4:0]  CMD_READ_CONFIG_COMMAND      = 5'h04;
   localparam logic [4:0]  CMD_START     = 5'h05;
   localparam logic [4:0]  CMD_RESET_CRC_COMMAND      = 5'h07;
   localparam logic [4:0]  CMD_SHUTDOWN  = 5'h0b;
   localparam logic [4:0]  CMD_DESYNCHRONISE_COMMAND   = 5'h0d;

   localparam int unsigned STAT_SYNC_BIT = 0;
   localparam int unsigned STAT_DOWN_BIT = 1;
   localparam int unsigned STAT_READ_CONFIG_COMMAND_BIT = 2;

   localparam logic [27:0] DUMMY_WORDS   = 28'h000002a;
   localparam logic [31:0] FRAME_WORDS   = 32'h00000008;
   localparam logic [27:0] LEAD_WORDS    = DUMMY_WORDS + FRAME_WORDS[27:0];
   localparam int unsigned MEM_AW        = 8;

   localparam logic [1:0]  PW_X8         = 2'h0;
   localparam logic [1:0]  PW_X16        = 2'h1;
   localparam logic [2:0]  LAT_X8        = 3'h1;
   localparam logic [2:0]  LAT_X16       = 3'h3;
   localparam logic [2:0]  LAT_X32       = 3'h4;

   typedef enum logic [2:0] {
      PK_UNSYNC = 3'b001,
      PK_HEADER = 3'b010,
      PK_DATA   = 3'b100
   } pcr_pk_state_t;

   typedef enum logic [3:0] {
      SQ_RUN   = 4'b0001,
      SQ_SHUT  = 4'b0010,
      SQ_DOWN  = 4'b0100,
      SQ_START = 4'b1000
   } pcr_sq_state_t;
endpackage

// [rtl/pcr_sync.sv]
// Purpose: two-flop level synchroniser
// Assumes: input is a level that is stable for several destination clocks
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module pcr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule // pcr_sync

// [rtl/pcr_frame_mem.sv]
// Purpose: configuration frame memory, loaded on the system clock
// Assumes: read side runs on the configuration clock
// Notes:   registered read data, one cycle latency
`timescale 1ns/1ps
module pcr_frame_mem import pcr_pkg::*; (
   input  wire logic              i_wr_clock,
   input  wire logic              i_wr_en,
   input  wire logic [MEM_AW-1:0] i_wr_addr,
   input  wire logic [31:0]       i_wr_data,
   input  wire logic              i_rd_clock,
   input  wire logic [MEM_AW-1:0] i_rd_addr,
   output logic      [31:0]       o_rd_data
);
   logic [31:0] store [0:(1<<MEM_AW)-1];

   always_ff @(posedge i_wr_clock) begin
      if (i_wr_en) begin
         store[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_rd_clock) begin
      o_rd_data <= store[i_rd_addr];
   end
endmodule // pcr_frame_mem

// [rtl/pcr_readback.sv]
// Purpose: device side of the parallel config port: packets, shutdown, readback
// Assumes: host drives port pins synchronous to the configuration clock
// Notes:   sequencer on i_clock, port logic on the configuration clock
//
// Functional notes
// R1 - host puts other register address and word count in type-1 read header
// R2 - host discards first returned frame, it comes from the frame buffer
// R3 - host starts with dummy, width sync/detect, dummy, sync, one no-op
// R4 - host sends one-word command header, shutdown code, one no-op
// R5 - host then sends reset-crc command and one no-op
// R6 - host sends five no-ops so shutdown finishes first
// R7 - done output low while shutdown sequence runs
// R8 - host sends read-config command and one no-op
// R9 - host loads start frame address with one-word write header
// R10 - readout request is type-1 read zero count then type-2 read count
// R11 - byte-wide mode count holds one extra word, device returns it
// R12 - returned length includes one leading dummy frame from frame buffer
// R13 - host sends 32 no-ops before switching port to read
// R14 - after readout host sends no-op, start command, no-op
// R15 - host ends with reset-crc, desynchronise, 64 no-op bits, clocks until done
// R16 - host captures words only while readout-wait is low
// R17 - readback begins with 42 dummy words, scaled by lanes in narrow modes
// R18 - read to readout-wait latency is 1, 3, 4 clocks for x8, x16, x32
// R19 - latencies assume select deasserted one cycle at direction change
// R20 - direction change while selected aborts the operation
// R21 - data pins input while write control, output while read control
// R22 - host returns to write control right after last readout word
`timescale 1ns/1ps
module pcr_readback import pcr_pkg::*; (
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   input  wire logic              i_configuration_clock,
   input  wire logic              i_port_select_n,
   input  wire logic              i_read_write_n,
   input  wire logic [1:0]        i_port_width,
   input  wire logic [31:0]       i_data,
   input  wire logic              i_mem_wr,
   input  wire logic [MEM_AW-1:0] i_mem_addr,
   input  wire logic [31:0]       i_mem_wdata,
   output logic      [31:0]       o_data,
   output logic                   o_data_oe_n,
   output logic                   o_readout_wait,
   output logic                   o_config_done
);
   // system clock domain: shutdown / startup sequencer
   pcr_sq_state_t sq_state, next_sq_state;
   logic [7:0]    sq_cnt, next_sq_cnt;
   logic          sq_down, next_sq_down;
   logic          next_done;
   logic [1:0]    mn_tgl, mn_tgl_q;
   logic          shut_evt, start_evt;
   logic          shut_tgl, start_tgl;

   pcr_sync #(.WIDTH(2)) u_main_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_d     ({start_tgl, shut_tgl}),
      .o_q     (mn_tgl)
   );

   assign shut_evt  = mn_tgl[0] ^ mn_tgl_q[0];
   assign start_evt = mn_tgl[1] ^ mn_tgl_q[1];

   always_comb begin
      next_sq_state = sq_state;
      next_sq_cnt   = sq_cnt;
      next_sq_down  = sq_down;
      next_done     = o_config_done;
      case (sq_state)
         SQ_RUN: begin
            if (shut_evt) begin
               next_sq_state = SQ_SHUT;
               next_sq_cnt   = SHUT_LOAD;
               next_done     = 1'b0; // R7
            end
         end
         SQ_SHUT: begin
            next_sq_cnt = sq_cnt - 8'h01;
            if (sq_cnt == 8'h00) begin
               next_sq_state = SQ_DOWN;
               next_sq_down  = 1'b1;
            end
         end
         SQ_DOWN: begin
            if (start_evt) begin
               next_sq_state = SQ_START;
               next_sq_cnt   = START_LOAD;
               next_sq_down  = 1'b0;
            end
         end
         SQ_START: begin
            next_sq_cnt = sq_cnt - 8'h01;
            if (sq_cnt == 8'h00) begin
               next_sq_state = SQ_RUN;
               next_done     = 1'b1;
            end
         end
         default: begin
            next_sq_state = SQ_RUN;
            next_done     = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sq_state      <= SQ_RUN;
         sq_cnt        <= 8'h00;
         sq_down       <= 1'b0;
         o_config_done <= 1'b1;
         mn_tgl_q      <= 2'h0;
      end else begin
         sq_state      <= next_sq_state;
         sq_cnt        <= next_sq_cnt;
         sq_down       <= next_sq_down;
         o_config_done <= next_done;
         mn_tgl_q      <= mn_tgl;
      end
   end

   // configuration clock domain
   logic [2:0]  lk_sync;
   logic [1:0]  pw;
   logic [1:0]  lanes_m1;
   logic        wr_sel, rd_sel, sel_q, dir_q, abort;

   pcr_sync #(.WIDTH(3)) u_link_sync (
      .i_clock (i_configuration_clock),
      .i_rst   (i_rst),
      .i_d     ({sq_down, i_port_width}),
      .o_q     (lk_sync)
   );

   assign pw       = lk_sync[1:0];
   assign lanes_m1 = (pw == PW_X8) ? 2'h3 : (pw == PW_X16) ? 2'h1 : 2'h0;
   assign wr_sel   = !i_port_select_n && !i_read_write_n; // R21
   assign rd_sel   = !i_port_select_n && i_read_write_n; // R21
   assign abort    = !i_port_select_n && sel_q && (i_read_write_n != dir_q); // R20

   // packet processor
   pcr_pk_state_t pk_state, next_pk_state;
   logic [31:0] acc, next_acc, asm_word, frame_address_register, next_far, status, arm_val;
   logic [1:0]  lane_in, next_lane_in;
   logic [26:0] wc, next_wc, arm_count;
   logic [4:0]  last_reg, next_last_reg, sel_reg;
   logic        read_config_command, next_read_config_command, next_shut_tgl, next_start_tgl;
   logic        arm, arm_frame_readout_register;
   logic [2:0]  hdr_type;
   logic [1:0]  hdr_op;

   always_comb begin
      case (pw)
         PW_X8:   asm_word = {acc[23:0], i_data[7:0]};
         PW_X16:  asm_word = {acc[15:0], i_data[15:0]};
         default: asm_word = i_data;
      endcase
      hdr_type = asm_word[TYPE_LSB +: 3];
      hdr_op   = asm_word[OP_LSB +: 2];
      sel_reg  = (hdr_type == HDR_TYPE1) ? asm_word[REG_LSB +: 5] : last_reg;
      status   = 32'h0;
      status[STAT_SYNC_BIT] = (pk_state != PK_UNSYNC);
      status[STAT_DOWN_BIT] = lk_sync[2];
      status[STAT_READ_CONFIG_COMMAND_BIT] = read_config_command;
      arm_val  = (sel_reg == REG_FAR) ? frame_address_register : (sel_reg == REG_STAT) ? status : 32'h0;
      next_pk_state  = pk_state;
      next_acc       = acc;
      next_lane_in   = lane_in;
      next_wc        = wc;
      next_last_reg  = last_reg;
      next_far       = frame_address_register;
      next_read_config_command      = read_config_command;
      next_shut_tgl  = shut_tgl;
      next_start_tgl = start_tgl;
      arm            = 1'b0;
      arm_frame_readout_register       = 1'b0;
      arm_count      = 27'h0;
      if (abort) begin
         next_pk_state = PK_UNSYNC; // R20
         next_lane_in  = 2'h0;
         next_read_config_command     = 1'b0;
      end else if (wr_sel) begin
         next_acc     = asm_word;
         next_lane_in = (lane_in == lanes_m1) ? 2'h0 : lane_in + 2'h1;
         if (lane_in == lanes_m1) begin
            case (pk_state)
               PK_UNSYNC: begin
                  if (asm_word == SYNC_WORD) begin
                     next_pk_state = PK_HEADER;
                  end
               end
               PK_HEADER: begin
                  if (hdr_type == HDR_TYPE1) begin
                     next_last_reg = sel_reg;
                     next_wc       = {16'h0, asm_word[WC1_BITS-1:0]};
                     if (hdr_op == OP_WRITE && next_wc != 27'h0) begin
                        next_pk_state = PK_DATA;
                     end else if (hdr_op == OP_READ && next_wc != 27'h0
                                  && sel_reg != REG_FRAME_READOUT_REGISTER) begin
                        arm       = 1'b1;
                        arm_count = next_wc;
                     end
                  end else if (hdr_type == HDR_TYPE2) begin
                     next_wc = asm_word[WC2_BITS-1:0];
                     if (hdr_op == OP_WRITE && next_wc != 27'h0) begin
                        next_pk_state = PK_DATA;
                     end else if (hdr_op == OP_READ && next_wc != 27'h0) begin
                        arm       = 1'b1;
                        arm_count = next_wc; // R11
                        arm_frame_readout_register  = (last_reg == REG_FRAME_READOUT_REGISTER) && read_config_command;
                     end
                  end
               end
               PK_DATA: begin
                  next_wc = wc - 27'h1;
                  if (wc == 27'h1) begin
                     next_pk_state = PK_HEADER;
                  end
                  if (last_reg == REG_FAR) begin
                     next_far = asm_word;
                  end else if (last_reg == REG_CMD) begin
                     case (asm_word[4:0])
                        CMD_SHUTDOWN: next_shut_tgl  = !shut_tgl;
                        CMD_START:    next_start_tgl = !start_tgl;
                        CMD_READ_CONFIG_COMMAND:     next_read_config_command      = 1'b1;
                        CMD_DESYNCHRONISE_COMMAND: begin
                           next_pk_state = PK_UNSYNC;
                           next_read_config_command     = 1'b0;
                        end
                        default: next_read_config_command = read_config_command;
                     endcase
                  end
               end
               default: next_pk_state = PK_UNSYNC;
            endcase
         end
      end
   end

   always_ff @(posedge i_configuration_clock or posedge i_rst) begin
      if (i_rst) begin
         pk_state  <= PK_UNSYNC;
         acc       <= 32'h0;
         lane_in   <= 2'h0;
         wc        <= 27'h0;
         last_reg  <= 5'h0;
         frame_address_register       <= 32'h0;
         read_config_command      <= 1'b0;
         shut_tgl  <= 1'b0;
         start_tgl <= 1'b0;
         sel_q     <= 1'b0;
         dir_q     <= 1'b0;
      end else begin
         pk_state  <= next_pk_state;
         acc       <= next_acc;
         lane_in   <= next_lane_in;
         wc        <= next_wc;
         last_reg  <= next_last_reg;
         frame_address_register       <= next_far;
         read_config_command      <= next_read_config_command;
         shut_tgl  <= next_shut_tgl;
         start_tgl <= next_start_tgl;
         sel_q     <= !i_port_select_n;
         dir_q     <= i_read_write_n;
      end
   end

   // readout engine
   logic        ro_pend, next_ro_pend, ro_frame_readout_register, next_ro_frame_readout_register, rd_sel_q;
   logic [27:0] ro_total, next_ro_total, idx, next_idx;
   logic [31:0] ro_val, next_ro_val, src, shifted, slice, next_data, mem_off, mem_rdata;
   logic [1:0]  lane_o, next_lane_o;
   logic [2:0]  lat, next_lat;
   logic        rd_start, emit, last_lane;
   logic [4:0]  sh;

   assign rd_start  = rd_sel && !rd_sel_q;
   assign emit      = rd_sel && !rd_start && lat == 3'h0 && ro_pend; // R18
   assign last_lane = (lane_o == lanes_m1);
   assign next_idx  = (emit && last_lane) ? idx + 28'h1 : idx;
   assign mem_off   = {4'h0, next_idx} - {4'h0, LEAD_WORDS} + frame_address_register * FRAME_WORDS; // R12

   pcr_frame_mem u_frame_mem (
      .i_wr_clock (i_clock),
      .i_wr_en    (i_mem_wr),
      .i_wr_addr  (i_mem_addr),
      .i_wr_data  (i_mem_wdata),
      .i_rd_clock (i_configuration_clock),
      .i_rd_addr  (mem_off[MEM_AW-1:0]),
      .o_rd_data  (mem_rdata)
   );

   always_comb begin
      if (!ro_frame_readout_register) begin
         src = ro_val;
      end else if (idx < LEAD_WORDS) begin
         src = 32'h0; // R17
      end else begin
         src = mem_rdata;
      end
      sh      = (pw == PW_X16) ? {lane_o[0], 4'h0} : {lane_o, 3'h0};
      shifted = src << sh;
      case (pw)
         PW_X8:   slice = {24'h0, shifted[31:24]};
         PW_X16:  slice = {16'h0, shifted[31:16]};
         default: slice = src;
      endcase
      next_data     = emit ? slice : o_data;
      next_lane_o   = emit ? (last_lane ? 2'h0 : lane_o + 2'h1) : lane_o;
      next_ro_pend  = ro_pend;
      next_ro_frame_readout_register  = ro_frame_readout_register;
      next_ro_total = ro_total;
      next_ro_val   = ro_val;
      next_lat      = lat;
      if (rd_start) begin
         next_lat = (pw == PW_X8) ? LAT_X8 - 3'h1 :
                    (pw == PW_X16) ? LAT_X16 - 3'h1 : LAT_X32 - 3'h1; // R18
      end else if (rd_sel && lat != 3'h0) begin
         next_lat = lat - 3'h1;
      end
      if (abort) begin
         next_ro_pend = 1'b0; // R20
      end else if (arm) begin
         next_ro_pend  = 1'b1;
         next_ro_frame_readout_register  = arm_frame_readout_register;
         next_ro_total = arm_frame_readout_register ? {1'b0, arm_count} + DUMMY_WORDS : {1'b0, arm_count}; // R17
         next_ro_val   = arm_val;
         next_lane_o   = 2'h0;
      end else if (emit && last_lane && next_idx == ro_total) begin
         next_ro_pend = 1'b0;
      end
   end

   always_ff @(posedge i_configuration_clock or posedge i_rst) begin
      if (i_rst) begin
         ro_pend        <= 1'b0;
         ro_frame_readout_register        <= 1'b0;
         ro_total       <= 28'h0;
         ro_val         <= 32'h0;
         idx            <= 28'h0;
         lane_o         <= 2'h0;
         lat            <= 3'h0;
         rd_sel_q       <= 1'b0;
         o_data         <= 32'h0;
         o_data_oe_n    <= 1'b1;
         o_readout_wait <= 1'b1;
      end else begin
         ro_pend        <= next_ro_pend;
         ro_frame_readout_register        <= next_ro_frame_readout_register;
         ro_total       <= next_ro_total;
         ro_val         <= next_ro_val;
         idx            <= arm ? 28'h0 : next_idx;
         lane_o         <= next_lane_o;
         lat            <= next_lat;
         rd_sel_q       <= rd_sel;
         o_data         <= next_data;
         o_data_oe_n    <= !rd_sel; // R21
         o_readout_wait <= !emit; // R16
      end
   end

   // assertion helpers: units emitted against units expected
   logic [31:0] hp_units, hp_expect;
   always_ff @(posedge i_configuration_clock or posedge i_rst) begin
      if (i_rst) begin
         hp_units  <= 32'h0;
         hp_expect <= 32'h0;
      end else if (arm) begin
         hp_units  <= 32'h0;
         hp_expect <= {4'h0, next_ro_total} * {29'h0, {1'b0, lanes_m1} + 3'h1};
      end else if (emit) begin
         hp_units  <= hp_units + 32'h1;
      end
   end

   chk_done_low_shut: assert property (@(posedge i_clock) disable iff (i_rst) // R7
      (shut_evt && sq_state == SQ_RUN) |=> !o_config_done [*8])
      else $error("done not low during shutdown");
   chk_oe_read_dir: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R21
      rd_sel |=> !o_data_oe_n)
      else $error("data pins not driven under read control");
   chk_oe_write_dir: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R21
      !i_read_write_n |=> o_data_oe_n)
      else $error("data pins driven under write control");
   chk_wait_lat_x8: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R18
      (rd_start && ro_pend && pw == PW_X8) ##1 rd_sel |=> !o_readout_wait && $past(o_readout_wait))
      else $error("x8 readout-wait latency wrong");
   chk_wait_lat_x16: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R18
      (rd_start && ro_pend && pw == PW_X16) ##1 rd_sel [*3]
      |=> !o_readout_wait && $past(o_readout_wait))
      else $error("x16 readout-wait latency wrong");
   chk_wait_lat_x32: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R18
      (rd_start && ro_pend && pw != PW_X8 && pw != PW_X16) ##1 rd_sel [*4]
      |=> !o_readout_wait && $past(o_readout_wait))
      else $error("x32 readout-wait latency wrong");
   chk_dummy_words: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R17
      (emit && ro_frame_readout_register && idx < DUMMY_WORDS) |=> (o_data == 32'h0) && !o_readout_wait)
      else $error("leading dummy word not zero");
   chk_readout_len: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R12
      ($fell(ro_pend) && $past(emit)) |-> hp_units == hp_expect)
      else $error("readout length differs from requested count");
   chk_abort_cancel: assert property (@(posedge i_configuration_clock) disable iff (i_rst) // R20
      abort |=> !ro_pend && pk_state == PK_UNSYNC)
      else $error("direction change while selected did not abort");

   cov_readout_done: cover property (@(posedge i_configuration_clock) disable iff (i_rst)
      $fell(ro_pend) && $past(emit) && $past(ro_frame_readout_register));
   cov_restart: cover property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_config_done));
   cov_abort: cover property (@(posedge i_configuration_clock) disable iff (i_rst)
      abort && ro_pend);
endmodule // pcr_readback

// [test/pcr_host.sv]
// Purpose: host model driving the parallel config port
// Assumes: pins change just after config clock edges
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module pcr_host import pcr_pkg::*; (
   input  wire logic        i_configuration_clock,
   input  wire logic [1:0]  i_port_width,
   input  wire logic [31:0] i_data,
   input  wire logic        i_data_oe_n,
   input  wire logic        i_readout_wait,
   output logic             o_port_select_n,
   output logic             o_read_write_n,
   output logic      [31:0] o_data
);
   logic [31:0] got[$];
   logic [31:0] msk;
   int          lat;
   int          oe_err;
   int          n;
   assign n = (i_port_width == PW_X8) ? 4 : (i_port_width == PW_X16) ? 2 : 1;
   assign msk = 32'hffffffff >> (32 - 32 / n);
   initial begin
      o_port_select_n = 1'b1;
      o_read_write_n  = 1'b0;
      o_data          = 32'h0;
   end
   // msb lane first, release after the burst
   task automatic send(input logic [31:0] ws[$]);
      foreach (ws[i]) begin
         for (int k = n - 1; k >= 0; k--) begin
            @(posedge i_configuration_clock);
            o_port_select_n <= 1'b0;
            o_data          <= (ws[i] >> (k * 32 / n)) & msk;
         end
      end
      @(posedge i_configuration_clock);
      o_port_select_n <= 1'b1;
      o_data          <= ~o_data;
   endtask
   // direction change while selected, device must abort
   task automatic flip();
      @(posedge i_configuration_clock);
      o_read_write_n  <= 1'b1;
      @(posedge i_configuration_clock);
      o_port_select_n <= 1'b0;
      @(posedge i_configuration_clock);
      o_read_write_n  <= 1'b0;
      @(posedge i_configuration_clock);
      o_port_select_n <= 1'b1;
   endtask
   task automatic rd(input int total);
      int units;
      got    = {};
      lat    = 0;
      oe_err = 0;
      units  = 0;
      @(posedge i_configuration_clock);
      o_read_write_n  <= 1'b1;
      o_port_select_n <= 1'b0;
      while (units < total && lat < 300) begin
         @(posedge i_configuration_clock);
         if (units == 0) lat++;
         if (i_readout_wait === 1'b0) begin
            if (i_data_oe_n !== 1'b0) oe_err++;
            if (units % n == 0) got.push_back(i_data & msk);
            else got[$] = (got[$] << (32 / n)) | (i_data & msk);
            units++;
         end
      end
      o_port_select_n <= 1'b1;
      @(posedge i_configuration_clock);
      o_read_write_n <= 1'b0;
   endtask
endmodule // pcr_host

// [test/tb_top.sv]
// Purpose: self-checking bench for the config port readback block
// Assumes: host model drives the port on a free 30 ns config clock
// Notes:   x32, x16 and x8 readback with shutdown and restart
`timescale 1ns/1ps
module tb_top;
   import pcr_pkg::*;
   localparam logic [31:0] NO_OP_WORD = 32'h20000000;
   localparam logic [31:0] CMD_HDR    = 32'h30008001;
   logic              i_clock;
   logic              i_rst;
   logic              cfg_clock;
   logic              sel_n;
   logic              rdwr_n;
   logic              oe_n;
   logic              readout_wait;
   logic              done;
   logic              mem_wr;
   logic [1:0]        width;
   logic [MEM_AW-1:0] mem_addr;
   logic [31:0]       host_data;
   logic [31:0]       dev_data;
   logic [31:0]       mem_wdata;
   int                failures;
   int                checked;
   pcr_readback DUT (.i_clock(i_clock), .i_rst(i_rst), .i_configuration_clock(cfg_clock),
      .i_port_select_n(sel_n), .i_read_write_n(rdwr_n), .i_port_width(width),
      .i_data(host_data), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
      .o_data(dev_data), .o_data_oe_n(oe_n), .o_readout_wait(readout_wait),
      .o_config_done(done));
   pcr_host host (.i_configuration_clock(cfg_clock), .i_port_width(width), .i_data(dev_data),
      .i_data_oe_n(oe_n), .i_readout_wait(readout_wait), .o_port_select_n(sel_n),
      .o_read_write_n(rdwr_n), .o_data(host_data));
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   initial begin
      cfg_clock = 1'b0;
      #7;
      forever #15 cfg_clock = ~cfg_clock;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic do_reset(input logic [1:0] w);
      @(posedge i_clock);
      i_rst <= 1'b1;
      width <= w;
      repeat (3) @(posedge cfg_clock);
      check("oe reset", oe_n, 1'b1);
      check("wait reset", readout_wait, 1'b1);
      check("done reset", done, 1'b1);
      @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (3) @(posedge cfg_clock);
      for (int a = 0; a < 16; a++) begin
         @(posedge i_clock);
         mem_wr    <= 1'b1;
         mem_addr  <= MEM_AW'(a);
         mem_wdata <= 32'hc0de0000 + a;
      end
      @(posedge i_clock);
      mem_wr <= 1'b0;
   endtask
   task automatic prep();
      host.send('{32'hffffffff, 32'h000000bb, 32'h11220044, 32'hffffffff});
      host.send('{SYNC_WORD, NO_OP_WORD});
      host.send('{CMD_HDR, 32'h0000000b, NO_OP_WORD});
      host.send('{CMD_HDR, 32'h00000007, NO_OP_WORD});
      host.send('{NO_OP_WORD, NO_OP_WORD, NO_OP_WORD, NO_OP_WORD, NO_OP_WORD});
      check("done shut", done, 1'b0);
      host.send('{CMD_HDR, 32'h00000004, NO_OP_WORD});
      host.send('{32'h30002001, 32'h00000003, 32'h28002001, NO_OP_WORD, NO_OP_WORD});
      host.rd(host.n);
      check("reg read", host.got[0], 32'h00000003);
      host.send('{32'h30002001, 32'h00000000});
   endtask
   task automatic readback(input logic [31:0] cnt, input int lat_exp);
      host.send('{32'h28006000, 32'h48000000 | cnt});
      repeat (32) host.send('{NO_OP_WORD});
      host.rd((42 + cnt) * host.n);
      check("latency", host.lat, lat_exp);
      check("oe read", host.oe_err, 0);
      check("length", host.got.size(), 42 + cnt);
      foreach (host.got[i]) check("word", host.got[i], i < 50 ? 0 : 32'hc0de0000 + i - 50);
      host.send('{NO_OP_WORD, CMD_HDR, 32'h00000005, NO_OP_WORD});
      host.send('{CMD_HDR, 32'h00000007, NO_OP_WORD, CMD_HDR, 32'h0000000d});
      host.send('{NO_OP_WORD, NO_OP_WORD});
      for (int k = 0; k < 200 && done !== 1'b1; k++) host.send('{NO_OP_WORD});
      check("done up", done, 1'b1);
   endtask
   task automatic t_x32();
      do_reset(2'h2);
      prep();
      readback(32'd24, 6);
   endtask
   task automatic t_abort();
      host.send('{SYNC_WORD, NO_OP_WORD, 32'h28002001});
      host.flip();
      host.rd(host.n);
      check("abort", host.got.size(), 0);
   endtask
   task automatic t_x16();
      do_reset(PW_X16);
      prep();
      readback(32'd16, 5);
   endtask
   task automatic t_x8();
      do_reset(PW_X8);
      prep();
      readback(32'd17, 3);
   endtask
   initial begin
      i_rst     = 1'b1;
      width     = 2'h2;
      mem_wr    = 1'b0;
      mem_addr  = '0;
      mem_wdata = 32'h0;
      failures  = 0;
      checked   = 0;
      t_x32();
      t_abort();
      t_x16();
      t_x8();
      complete_run();
   end
   initial begin
      #2000000;
      failures++;
      complete_run();
   end
endmodule // tb_top
